//--- logic/mag_defs.svh
`ifndef MAG_DEFS_SVH
`define MAG_DEFS_SVH

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define MAG_CLK_MHZ 100
`define MAG_QTR_NS 625
`define MAG_QTR_CYC ((`MAG_QTR_NS * `MAG_CLK_MHZ + 999) / 1000)
`define MAG_MEAS_NS 20000
`define MAG_MEAS_CYC ((`MAG_MEAS_NS * `MAG_CLK_MHZ + 999) / 1000)

// ----------------------------------------------------------------------------
// Device link address and register map
// ----------------------------------------------------------------------------
`define MAG_DEV_ADDR 7'h20
`define MAG_REG_POLL 8'h00
`define MAG_REG_CMM 8'h01
`define MAG_REG_CC_FIRST 8'h04
`define MAG_REG_CC_LAST 8'h09
`define MAG_REG_RES_FIRST 8'h24
`define MAG_REG_RES_LAST 8'h2c
`define MAG_REG_STATUS 8'h34
`define MAG_REG_HANDSHAKE_CONTROL 8'h35
`define MAG_CMM_RUN_BIT 0
`define MAG_POLL_AXES 6:4
`define MAG_HS_DRC_RST 2'h3
`define MAG_HS_FIXED 2'h2
`define MAG_CC_REGS 6
`define MAG_RES_BYTES 9

// ----------------------------------------------------------------------------
// Controller register map (APB)
// ----------------------------------------------------------------------------
`define MAG_APB_CMD 8'h00
`define MAG_APB_STATUS 8'h04
`define MAG_APB_IRQ_STAT 8'h08
`define MAG_APB_IRQ_MASK 8'h0c
`define MAG_APB_DATA0 8'h10
`define MAG_CMD_READ_BIT 12
`define MAG_CMD_GO_BIT 13
`define MAG_BUF_WORDS 4'h9
`define MAG_IRQ_DONE 0
`define MAG_IRQ_NACK 1
`define MAG_IRQ_READY 2

`endif

//--- logic/mag_pkg.sv
package mag_pkg;
  typedef logic [7:0] mag_byte_t;
  typedef logic [23:0] mag_sample_t;
  typedef enum logic [2:0] {
    MAG_DS_IDLE = 3'b000,
    MAG_DS_RECV = 3'b001,
    MAG_DS_ACK = 3'b010,
    MAG_DS_SEND = 3'b011,
    MAG_DS_RACK = 3'b100
  } mag_dev_state_e;
  typedef enum logic [1:0] {
    MAG_HS_IDLE = 2'b00,
    MAG_HS_START = 2'b01,
    MAG_HS_XFER = 2'b10,
    MAG_HS_STOP = 2'b11
  } mag_host_state_e;
endpackage

//--- logic/mag_if.sv
`timescale 1ns/1ps
`default_nettype none
interface mag_if;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic result_ready_pin;
  logic scl;
  logic sda;
  // Open-drain wires: any enabled low driver pulls the line down.
  assign scl = !(host_scl_oe && !host_scl_o);
  assign sda = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));
  modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe,
    output result_ready_pin);
  modport host (input scl, input sda, input result_ready_pin, output host_scl_o,
    output host_scl_oe, output host_sda_o, output host_sda_oe);
endinterface
`default_nettype wire

//--- logic/mag_dev.sv
// What this block does
// [RULE_01] Burst write fills consecutive cycle-count registers
// [RULE_02] Host writes counts high then low, X-Y-Z
// [RULE_03] Single measurement: address, axis byte, stop
// [RULE_04] Measurement runs in background, bus stays free
// [RULE_05] Completion raises ready pin and status bit 7
// [RULE_06] After single measurement, device goes idle
// [RULE_07] Host writes continuous control to start continuous mode
// [RULE_08] Read starts by writing only result address
// [RULE_09] Nine result bytes returned, pointer auto-increments
// [RULE_10] Stop ends any transfer cleanly
// [RULE_11] First result byte sent clears ready indication; code clears it on the read address with the pointer on a result register
// [RULE_12] All-axes single measurement byte is 0x70
// [RULE_13] All-axes continuous control value is 0x79
// [RULE_14] Early result read sets error flag
// [RULE_15] Device acknowledges address, register and data bytes
//
// Decided for this implementation: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "mag_defs.svh"
module mag_dev (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Serial link.
  mag_if.dev link,
  // Sensor samples.
  input wire mag_pkg::mag_sample_t x_field,
  input wire mag_pkg::mag_sample_t y_field,
  input wire mag_pkg::mag_sample_t z_field,
  // Status.
  output logic meas_active
);
  import mag_pkg::*;

  // --------------------------------------------------------------------------
  // Pin synchronisers and bus conditions
  // --------------------------------------------------------------------------
  logic [1:0] scl_sync_q;
  logic [1:0] sda_sync_q;
  logic scl_prev_q;
  logic sda_prev_q;
  logic scl_s;
  logic sda_s;
  logic start_seen;
  logic stop_seen;
  logic scl_rise;
  logic scl_fall;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_sync_q <= 2'h3;
      sda_sync_q <= 2'h3;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_sync_q <= {scl_sync_q[0], link.scl};
      sda_sync_q <= {sda_sync_q[0], link.sda};
      scl_prev_q <= scl_sync_q[1];
      sda_prev_q <= sda_sync_q[1];
    end
  end

  assign scl_s = scl_sync_q[1];
  assign sda_s = sda_sync_q[1];
  assign start_seen = scl_s && scl_prev_q && sda_prev_q && !sda_s;
  assign stop_seen = scl_s && scl_prev_q && !sda_prev_q && sda_s;
  assign scl_rise = scl_s && !scl_prev_q;
  assign scl_fall = !scl_s && scl_prev_q;

  function automatic logic is_result(input logic [7:0] a);
    is_result = (a >= `MAG_REG_RES_FIRST) && (a <= `MAG_REG_RES_LAST);
  endfunction

  // --------------------------------------------------------------------------
  // Byte engine
  // --------------------------------------------------------------------------
  mag_dev_state_e st_q;
  logic [2:0] bit_q;
  logic [7:0] sh_q;
  logic sda_oe_q;
  logic rw_q;
  logic is_addr_q;
  logic is_ptr_q;
  logic [7:0] ptr_q;
  logic [7:0] full_byte;
  logic [7:0] rd_data;
  logic byte_done;
  logic addr_hit;
  logic rd_start;
  logic ptr_wr;
  logic reg_wr;
  logic host_acked;

  assign full_byte = {sh_q[6:0], sda_s};
  assign byte_done = (st_q == MAG_DS_RECV) && scl_rise && (bit_q == 3'h7);
  assign addr_hit = byte_done && is_addr_q && (full_byte[7:1] == `MAG_DEV_ADDR);
  assign rd_start = addr_hit && full_byte[0];
  assign ptr_wr = byte_done && !is_addr_q && is_ptr_q;
  assign reg_wr = byte_done && !is_addr_q && !is_ptr_q;
  assign host_acked = (st_q == MAG_DS_RACK) && scl_rise && !sda_s;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= MAG_DS_IDLE;
      bit_q <= 3'h0;
      sh_q <= 8'h00;
      sda_oe_q <= 1'b0;
      rw_q <= 1'b0;
      is_addr_q <= 1'b0;
      is_ptr_q <= 1'b0;
    end else if (start_seen) begin
      st_q <= MAG_DS_RECV;
      bit_q <= 3'h0;
      sda_oe_q <= 1'b0;
      is_addr_q <= 1'b1;
    end else if (stop_seen) begin
      st_q <= MAG_DS_IDLE; // RULE_10
      sda_oe_q <= 1'b0;
    end else begin
      unique case (st_q)
        MAG_DS_IDLE: begin
          sda_oe_q <= 1'b0;
        end
        MAG_DS_RECV: begin
          if (scl_rise) begin
            sh_q <= full_byte;
            bit_q <= bit_q + 3'h1;
            if (bit_q == 3'h7) begin
              if (is_addr_q) begin
                rw_q <= full_byte[0];
              end
              if (is_addr_q && !addr_hit) begin
                st_q <= MAG_DS_IDLE;
              end else begin
                st_q <= MAG_DS_ACK;
              end
            end
          end
        end
        MAG_DS_ACK: begin
          if (scl_fall && !sda_oe_q) begin
            sda_oe_q <= 1'b1; // RULE_15
          end else if (scl_fall) begin
            bit_q <= 3'h0;
            is_addr_q <= 1'b0;
            is_ptr_q <= is_addr_q; // RULE_08
            if (rw_q) begin
              st_q <= MAG_DS_SEND;
              sh_q <= rd_data;
              sda_oe_q <= !rd_data[7];
            end else begin
              st_q <= MAG_DS_RECV;
              sda_oe_q <= 1'b0;
            end
          end
        end
        MAG_DS_SEND: begin
          if (scl_fall) begin
            bit_q <= bit_q + 3'h1;
            sh_q <= {sh_q[6:0], 1'b0};
            if (bit_q == 3'h7) begin
              st_q <= MAG_DS_RACK;
              sda_oe_q <= 1'b0;
            end else begin
              sda_oe_q <= !sh_q[6];
            end
          end
        end
        MAG_DS_RACK: begin
          if (scl_rise && sda_s) begin
            st_q <= MAG_DS_IDLE;
          end else if (scl_fall) begin
            st_q <= MAG_DS_SEND; // RULE_09
            bit_q <= 3'h0;
            sh_q <= rd_data;
            sda_oe_q <= !rd_data[7];
          end
        end
        default: begin
          st_q <= MAG_DS_IDLE;
          sda_oe_q <= 1'b0;
        end
      endcase
    end
  end

  assign link.dev_sda_oe = sda_oe_q;
  assign link.dev_sda_o = 1'b0;

  // Register pointer: set by the first written byte, then steps per byte.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ptr_q <= 8'h00;
    end else if (ptr_wr) begin
      ptr_q <= full_byte; // RULE_08
    end else if (reg_wr || host_acked) begin
      ptr_q <= ptr_q + 8'h01; // RULE_01 RULE_09
    end
  end

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  logic [7:0] poll_q;
  logic [7:0] cmm_q;
  logic [7:0] cc_q [`MAG_CC_REGS];
  logic [7:0] res_q [`MAG_RES_BYTES];
  logic [1:0] drc_q;
  logic [2:0] err_q;
  logic result_ready_pin_q;
  logic [11:0] cnt_q;
  logic meas_pend_q;
  logic cont_run;
  logic single_busy;
  logic start_single;
  logic meas_done;
  logic is_cc;
  logic wr_defined;
  logic [2:0] err_set;
  logic err_clr;
  logic result_ready_pin_clr;
  mag_sample_t fld [3];

  assign cont_run = cmm_q[`MAG_CMM_RUN_BIT];
  assign single_busy = ((cnt_q != 12'h000) || meas_pend_q) && !cont_run;
  assign is_cc = (ptr_q >= `MAG_REG_CC_FIRST) && (ptr_q <= `MAG_REG_CC_LAST);
  assign wr_defined = is_cc || (ptr_q == `MAG_REG_POLL) || (ptr_q == `MAG_REG_CMM)
    || (ptr_q == `MAG_REG_HANDSHAKE_CONTROL);
  assign start_single = reg_wr && (ptr_q == `MAG_REG_POLL) && !cont_run
    && (|full_byte[`MAG_POLL_AXES]); // RULE_03 RULE_12

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      poll_q <= 8'h00;
      cmm_q <= 8'h00;
      drc_q <= `MAG_HS_DRC_RST;
      for (int i = 0; i < `MAG_CC_REGS; i++) begin
        cc_q[i] <= 8'h00;
      end
    end else if (reg_wr) begin
      if (ptr_q == `MAG_REG_POLL && !cont_run) begin
        poll_q <= full_byte;
      end
      if (ptr_q == `MAG_REG_CMM && !single_busy) begin
        cmm_q <= full_byte; // RULE_07 RULE_13
      end
      if (is_cc) begin
        cc_q[3'(ptr_q - `MAG_REG_CC_FIRST)] <= full_byte; // RULE_01
      end
      if (ptr_q == `MAG_REG_HANDSHAKE_CONTROL) begin
        drc_q <= full_byte[1:0];
      end
    end
  end

  // Handshake error flags, cleared when the host acknowledges a byte read from the handshake register.
  assign err_set[2] = rd_start && is_result(ptr_q) && !result_ready_pin_q; // RULE_14
  assign err_set[1] = reg_wr && (((ptr_q == `MAG_REG_POLL) && cont_run)
    || ((ptr_q == `MAG_REG_CMM) && single_busy));
  assign err_set[0] = reg_wr && !wr_defined;
  assign err_clr = host_acked && (ptr_q == `MAG_REG_HANDSHAKE_CONTROL);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_q <= 3'h0;
    end else begin
      err_q <= (err_clr ? 3'h0 : err_q) | err_set;
    end
  end

  // --------------------------------------------------------------------------
  // Measurement sequencer
  // --------------------------------------------------------------------------
  assign meas_done = (cnt_q == 12'h001);
  assign fld[0] = x_field;
  assign fld[1] = y_field;
  assign fld[2] = z_field;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= 12'h000;
    end else if (cnt_q != 12'h000) begin
      cnt_q <= cnt_q - 12'h001; // RULE_04
    end else if ((meas_pend_q && stop_seen) || cont_run) begin
      cnt_q <= 12'(`MAG_MEAS_CYC); // RULE_06
    end
  end

  // A single measurement waits for the stop that ends its command, so the bus is free.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meas_pend_q <= 1'b0;
    end else if (start_single) begin
      meas_pend_q <= 1'b1;
    end else if (stop_seen && (cnt_q == 12'h000)) begin
      meas_pend_q <= 1'b0; // RULE_04
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meas_active <= 1'b0;
    end else begin
      meas_active <= (cnt_q != 12'h000);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < `MAG_RES_BYTES; i++) begin
        res_q[i] <= 8'h00;
      end
    end else if (meas_done) begin
      for (int a = 0; a < 3; a++) begin
        for (int b = 0; b < 3; b++) begin
          res_q[a * 3 + b] <= fld[a][23 - 8 * b -: 8];
        end
      end
    end
  end

  // Ready pin: set on completion, cleared by write address or result read.
  assign result_ready_pin_clr = (drc_q[0] && ptr_wr)
    || (drc_q[1] && rd_start && is_result(ptr_q)); // RULE_11

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_ready_pin_q <= 1'b0;
    end else begin
      result_ready_pin_q <= meas_done || (result_ready_pin_q && !result_ready_pin_clr); // RULE_05
    end
  end

  assign link.result_ready_pin = result_ready_pin_q;

  // --------------------------------------------------------------------------
  // Read data
  // --------------------------------------------------------------------------
  always_comb begin
    rd_data = 8'h00;
    if (ptr_q == `MAG_REG_POLL) begin
      rd_data = poll_q;
    end else if (ptr_q == `MAG_REG_CMM) begin
      rd_data = cmm_q;
    end else if (is_cc) begin
      rd_data = cc_q[3'(ptr_q - `MAG_REG_CC_FIRST)];
    end else if (is_result(ptr_q)) begin
      rd_data = res_q[4'(ptr_q - `MAG_REG_RES_FIRST)]; // RULE_09
    end else if (ptr_q == `MAG_REG_STATUS) begin
      rd_data = {result_ready_pin_q, 7'h00}; // RULE_05
    end else if (ptr_q == `MAG_REG_HANDSHAKE_CONTROL) begin
      rd_data = {1'b0, err_q, `MAG_HS_FIXED, drc_q};
    end
  end
endmodule // mag_dev
`default_nettype wire

//--- logic/mag_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "mag_defs.svh"
module mag_host (
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interrupt.
  output logic irq,
  // Serial link.
  mag_if.host link
);
  import mag_pkg::*;

  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  logic [1:0] sda_sync_q;
  logic [1:0] rdy_sync_q;
  logic rdy_prev_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sda_sync_q <= 2'h3;
      rdy_sync_q <= 2'h0;
      rdy_prev_q <= 1'b0;
    end else begin
      sda_sync_q <= {sda_sync_q[0], link.sda};
      rdy_sync_q <= {rdy_sync_q[0], link.result_ready_pin};
      rdy_prev_q <= rdy_sync_q[1];
    end
  end

  // --------------------------------------------------------------------------
  // APB registers
  // --------------------------------------------------------------------------
  mag_host_state_e hs_q;
  logic [7:0] cmd_reg_q;
  logic [3:0] cmd_len_q;
  logic cmd_rd_q;
  logic [7:0] buf_q [`MAG_BUF_WORDS];
  logic [2:0] irq_stat_q;
  logic [2:0] irq_mask_q;
  logic [2:0] irq_ev;
  logic acc;
  logic wr;
  logic busy;
  logic go;
  logic [3:0] didx;
  logic dhit;
  logic hit;
  logic [31:0] rd_word;
  logic store;
  logic [3:0] idx_q;
  logic [7:0] rx_q;

  assign acc = psel && penable && pready;
  assign wr = acc && pwrite;
  assign busy = (hs_q != MAG_HS_IDLE);
  assign go = wr && (paddr == `MAG_APB_CMD) && pwdata[`MAG_CMD_GO_BIT] && !busy;
  assign didx = 4'((paddr - `MAG_APB_DATA0) >> 2);
  assign dhit = (paddr >= `MAG_APB_DATA0) && (paddr[1:0] == 2'h0)
    && (didx < `MAG_BUF_WORDS);
  assign hit = dhit || (paddr == `MAG_APB_CMD) || (paddr == `MAG_APB_STATUS)
    || (paddr == `MAG_APB_IRQ_STAT) || (paddr == `MAG_APB_IRQ_MASK);

  always_comb begin
    rd_word = 32'h0;
    if (paddr == `MAG_APB_CMD) begin
      rd_word = 32'({cmd_rd_q, cmd_len_q, cmd_reg_q});
    end else if (paddr == `MAG_APB_STATUS) begin
      rd_word = 32'({rdy_sync_q[1], busy});
    end else if (paddr == `MAG_APB_IRQ_STAT) begin
      rd_word = 32'(irq_stat_q);
    end else if (paddr == `MAG_APB_IRQ_MASK) begin
      rd_word = 32'(irq_mask_q);
    end else if (dhit) begin
      rd_word = 32'(buf_q[didx]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      prdata <= rd_word;
      pslverr <= psel && !penable && !hit;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_reg_q <= 8'h00;
      cmd_len_q <= 4'h0;
      cmd_rd_q <= 1'b0;
      irq_mask_q <= 3'h0;
    end else begin
      if (go) begin
        cmd_reg_q <= pwdata[7:0];
        cmd_len_q <= (pwdata[11:8] > `MAG_BUF_WORDS) ? `MAG_BUF_WORDS : pwdata[11:8];
        cmd_rd_q <= pwdata[`MAG_CMD_READ_BIT];
      end
      if (wr && paddr == `MAG_APB_IRQ_MASK) begin
        irq_mask_q <= pwdata[2:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 9; i++) begin
        buf_q[i] <= 8'h00;
      end
    end else if (store) begin
      buf_q[4'(idx_q - 4'h1)] <= rx_q;
    end else if (wr && dhit && !busy) begin
      buf_q[didx] <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat_q <= 3'h0;
      irq <= 1'b0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~((wr && paddr == `MAG_APB_IRQ_STAT) ? pwdata[2:0] : 3'h0))
        | irq_ev;
      irq <= |(irq_stat_q & irq_mask_q);
    end
  end

  // --------------------------------------------------------------------------
  // Serial engine
  // --------------------------------------------------------------------------
  logic [8:0] div_q;
  logic [1:0] ph_q;
  logic [3:0] bit_q;
  logic rph_q;
  logic scl_oe_q;
  logic sda_oe_q;
  logic nack_q;
  logic tick;
  logic rx;
  logic [3:0] last_idx;
  logic [7:0] tx_byte;
  logic again;

  assign tick = (div_q == 9'(`MAG_QTR_CYC - 1));
  assign rx = rph_q && (idx_q != 4'h0);
  assign last_idx = rph_q ? cmd_len_q : (cmd_rd_q ? 4'h1 : cmd_len_q + 4'h1);
  assign tx_byte = (idx_q == 4'h0) ? {`MAG_DEV_ADDR, rph_q} :
    ((idx_q == 4'h1) ? cmd_reg_q : buf_q[4'(idx_q - 4'h2)]);
  assign store = (hs_q == MAG_HS_XFER) && tick && (ph_q == 2'h3) && (bit_q == 4'h8) && rx;
  assign again = !rph_q && cmd_rd_q && !nack_q;
  assign irq_ev[`MAG_IRQ_DONE] = (hs_q == MAG_HS_STOP) && tick && (ph_q == 2'h3) && !again;
  assign irq_ev[`MAG_IRQ_NACK] = irq_ev[`MAG_IRQ_DONE] && nack_q;
  assign irq_ev[`MAG_IRQ_READY] = rdy_sync_q[1] && !rdy_prev_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_q <= 9'h0;
      ph_q <= 2'h0;
    end else if (!busy || tick) begin
      div_q <= 9'h0;
      ph_q <= busy ? ph_q + 2'h1 : 2'h0;
    end else begin
      div_q <= div_q + 9'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hs_q <= MAG_HS_IDLE;
      bit_q <= 4'h0;
      idx_q <= 4'h0;
      rph_q <= 1'b0;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
      nack_q <= 1'b0;
      rx_q <= 8'h00;
    end else if (go) begin
      hs_q <= MAG_HS_START;
      rph_q <= 1'b0;
      nack_q <= 1'b0;
    end else if (tick) begin
      unique case (hs_q)
        MAG_HS_IDLE: begin
          scl_oe_q <= 1'b0;
        end
        MAG_HS_START: begin
          if (ph_q == 2'h0) begin
            sda_oe_q <= 1'b0;
            scl_oe_q <= 1'b0;
          end else if (ph_q == 2'h1) begin
            sda_oe_q <= 1'b1;
          end else if (ph_q == 2'h2) begin
            scl_oe_q <= 1'b1;
          end else begin
            hs_q <= MAG_HS_XFER;
            bit_q <= 4'h0;
            idx_q <= 4'h0;
          end
        end
        MAG_HS_XFER: begin
          if (ph_q == 2'h0) begin
            if (bit_q == 4'h8) begin
              sda_oe_q <= rx && (idx_q != last_idx); // RULE_09
            end else begin
              sda_oe_q <= !rx && !tx_byte[~bit_q[2:0]]; // RULE_02
            end
          end else if (ph_q == 2'h1) begin
            scl_oe_q <= 1'b0;
          end else if (ph_q == 2'h2) begin
            if (bit_q != 4'h8 && rx) begin
              rx_q <= {rx_q[6:0], sda_sync_q[1]};
            end else if (bit_q == 4'h8 && !rx && sda_sync_q[1]) begin
              nack_q <= 1'b1;
            end
          end else begin
            scl_oe_q <= 1'b1;
            if (bit_q != 4'h8) begin
              bit_q <= bit_q + 4'h1;
            end else begin
              bit_q <= 4'h0;
              if (nack_q || idx_q == last_idx) begin
                hs_q <= MAG_HS_STOP; // RULE_03 RULE_08
              end else begin
                idx_q <= idx_q + 4'h1; // RULE_01
              end
            end
          end
        end
        MAG_HS_STOP: begin
          if (ph_q == 2'h0) begin
            sda_oe_q <= 1'b1;
          end else if (ph_q == 2'h1) begin
            scl_oe_q <= 1'b0;
          end else if (ph_q == 2'h2) begin
            sda_oe_q <= 1'b0; // RULE_10
          end else begin
            hs_q <= again ? MAG_HS_START : MAG_HS_IDLE;
            rph_q <= again;
          end
        end
        default: begin
          hs_q <= MAG_HS_IDLE;
        end
      endcase
    end
  end

  assign link.host_scl_oe = scl_oe_q;
  assign link.host_sda_oe = sda_oe_q;
  assign link.host_scl_o = 1'b0;
  assign link.host_sda_o = 1'b0;
endmodule // mag_host
`default_nettype wire

//--- verification/mag_props.sv
`timescale 1ns/1ps
`default_nettype none
module mag_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic host_scl_o,
  input wire logic host_scl_oe,
  input wire logic host_sda_o,
  input wire logic host_sda_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic result_ready_pin,
  input wire logic scl,
  input wire logic sda,
  input wire logic meas_active
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_scl_wire_lvl: assert property (scl == !host_scl_oe)
    else $error("scl level wrong");
  chk_sda_wire_lvl: assert property (sda == !(host_sda_oe || dev_sda_oe))
    else $error("sda level wrong");
  chk_od_drive_low: assert property (!host_scl_o && !host_sda_o && !dev_sda_o)
    else $error("open drain value high");
  chk_dev_data_steady: assert property (scl && $past(scl) |-> $stable(dev_sda_oe))
    else $error("device sda moved with scl high");
  chk_dev_ack_slot: assert property ($rose(dev_sda_oe) |-> !scl)
    else $error("device drive began with scl high");
  chk_ready_after_meas: assert property ($fell(meas_active) |-> ##[0:4] result_ready_pin)
    else $error("ready not raised after measurement");
  chk_ready_rise_end: assert property ($rose(result_ready_pin) |-> ##[0:2] !meas_active)
    else $error("ready rose during measurement");
  chk_meas_bus_free: assert property ($rose(meas_active) |-> scl && sda)
    else $error("measurement began with bus busy");
endmodule // mag_props
`default_nettype wire

//--- verification/magnetometer_i2c_command_readout_tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "mag_defs.svh"
module magnetometer_i2c_command_readout_tb;
  import mag_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, irq, meas_active, e;
  logic [31:0] exp_q [9] = '{32'h12, 32'h34, 32'h56, 32'hab, 32'hcd, 32'hef, 32'h0f, 32'h1e,
    32'h2d};
  int n_errors = 0, checked = 0, i, k;
  mag_if mag_if_i ();
  mag_dev mag_dev_i (.pclk(pclk), .presetn(presetn), .link(mag_if_i), .x_field(24'h123456),
    .y_field(24'habcdef), .z_field(24'h0f1e2d), .meas_active(meas_active));
  mag_host mag_host_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .link(mag_if_i));
  mag_props mag_props_i (.pclk(pclk), .presetn(presetn), .host_scl_o(mag_if_i.host_scl_o),
    .host_scl_oe(mag_if_i.host_scl_oe), .host_sda_o(mag_if_i.host_sda_o),
    .host_sda_oe(mag_if_i.host_sda_oe), .dev_sda_o(mag_if_i.dev_sda_o),
    .dev_sda_oe(mag_if_i.dev_sda_oe), .result_ready_pin(mag_if_i.result_ready_pin),
    .scl(mag_if_i.scl), .sda(mag_if_i.sda), .meas_active(meas_active));
  always #5 pclk = ~pclk;
  task check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task end_sim;
    $display("checked %0d n_errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task timeout;
    n_errors++;
    $display("[ERR] %0t wait ran out", $time);
    end_sim();
  endtask
  // The request stands until the rising edge at which pready is seen high; data is taken there.
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int j;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    j = 0;
    do begin
      @(posedge pclk);
      j++;
    end while (pready !== 1'b1 && j < 100);
    if (pready !== 1'b1) timeout();
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wait_idle;
    int j;
    for (j = 0; j < 15000; j++) begin
      apb(1'b0, `MAG_APB_STATUS, 32'h0);
      if (r[0] === 1'b0) return;
    end
    timeout();
  endtask
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (3) @(posedge pclk);
    apb(1'b1, `MAG_APB_IRQ_MASK, 32'h1);
    apb(1'b1, `MAG_APB_IRQ_STAT, 32'h7);
    check(32'(irq), 32'h0);
    apb(1'b1, `MAG_APB_DATA0, 32'h70);
    apb(1'b1, `MAG_APB_CMD, 32'h2100);
    wait_idle();
    apb(1'b0, `MAG_APB_IRQ_STAT, 32'h0);
    check(r & 32'h3, 32'h1);
    check(32'(irq), 32'h1);
    for (i = 0; i < 100 && meas_active !== 1'b1; i++) @(posedge pclk);
    check(32'(meas_active), 32'h1);
    for (i = 0; i < 3000 && mag_if_i.result_ready_pin !== 1'b1; i++) @(posedge pclk);
    if (i == 3000) timeout();
    apb(1'b0, `MAG_APB_STATUS, 32'h0);
    check(32'(r[1]), 32'h1);
    repeat (50) @(posedge pclk);
    check(32'(meas_active), 32'h0);
    apb(1'b1, `MAG_APB_IRQ_STAT, 32'h1);
    repeat (2) @(posedge pclk);
    check(32'(irq), 32'h0);
    $display("single measurement test done");
    apb(1'b1, `MAG_APB_CMD, 32'h3924);
    wait_idle();
    for (k = 0; k < 9; k++) begin
      apb(1'b0, 8'(`MAG_APB_DATA0 + 4 * k), 32'h0);
      check(r, exp_q[k]);
    end
    check(32'(mag_if_i.result_ready_pin), 32'h0);
    apb(1'b0, `MAG_APB_IRQ_STAT, 32'h0);
    check(32'(r[2]), 32'h1);
    apb(1'b0, 8'h40, 32'h0);
    check({e, r[30:0]}, 32'h80000000);
    $display("result read test done");
    apb(1'b1, `MAG_APB_CMD, 32'h3135);
    wait_idle();
    apb(1'b0, `MAG_APB_DATA0, 32'h0);
    check(r, 32'h4b);
    $display("handshake test done");
    apb(1'b1, `MAG_APB_DATA0, 32'h79);
    apb(1'b1, `MAG_APB_CMD, 32'h2101);
    wait_idle();
    for (i = 0; i < 3000 && mag_if_i.result_ready_pin !== 1'b1; i++) @(posedge pclk);
    if (i == 3000) timeout();
    repeat (4) @(posedge pclk);
    check(32'(meas_active), 32'h1);
    $display("continuous test done");
    end_sim();
  end
endmodule // magnetometer_i2c_command_readout_tb
`default_nettype wire
